// file: rtl/halt_idle_wakeup_control.sv
// Overview of operation
// RULE1: Halt with idle select set, core enable clear: core clock stops, others run.
// RULE2: Halt with both bits set: program stops, all clocks keep running.
// RULE3: Idle core-off entry clears watchdog; it runs only on sub clock source.
// RULE4: Idle core-on entry clears watchdog; it keeps counting from either source.
// RULE5: Any idle entry sets powered-down flag and clears timeout flag.
// RULE6: Idle keeps memory, registers and port states unchanged.
// RULE7: Wake on external reset, port A fall, interrupt or watchdog overflow.
// RULE8: Reset wake is full reset; watchdog wake starts a watchdog reset.
// RULE9: Powered-down flag cleared by power-up or clear, set by halt; the code also clears it on external reset.
// RULE10: Timeout in low power sets timeout flag, resets only PC and stack.
// RULE11: Enabled port A falling edge wakes; execution continues after halt.
// RULE12: Disabled interrupt or full stack wake resumes after halt, service deferred.
// RULE13: Enabled interrupt with stack room gets normal response at wake.
// RULE14: Interrupt flag pending before halt does not wake.
// RULE15: Crystals share one startup counter; low crystal waits for high crystal.
// RULE16: Deep sleep wake waits for fast oscillator ready before execution.
// RULE17: Watchdog base is sub clock or core clock divided by four.
// RULE18: Watchdog divides base by 2^13 to 2^20 per three-bit select.
// RULE19: Core-clocked peripherals follow the core clock source change.
// RULE20: Sub and watchdog base clocks run only while the watchdog is enabled.
// RULE21: Halt with idle clear and watchdog, detector off enters deep sleep.
// RULE22: Watchdog off only if configuration off and soft field equals 1010.
// RULE23: Idle bits are sampled when halt executes.
// RULE24: Port A edges are synchronised on the running clock before waking.
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`include "halt_idle_consts.svh"
module halt_idle_wakeup_control #(
    parameter int PORT_W = 8,
    parameter int WDT_W = 21
) (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Configuration and system
    input wire logic cfg_wdt_enable,
    input wire logic cfg_wdt_src_core,
    input wire logic lvd_on,
    input wire logic sub_clock_tick,
    input wire logic ext_reset_n,
    input wire logic [PORT_W-1:0] porta_pin,
    input wire logic [7:0] int_request,
    input wire logic [7:0] int_enable,
    input wire logic stack_full,
    input wire logic fast_osc_ready,
    // Clock gating and wake outputs
    output logic core_clock_en,
    output logic time_base_clock_en,
    output logic sub_clock_en,
    output logic watchdog_base_en,
    output logic osc_startup_busy,
    output logic halted,
    output logic full_reset,
    output logic watchdog_reset,
    output logic int_service,
    output logic resume_after_halt
);
    initial begin
        if (PORT_W < 1 || PORT_W > 8 || WDT_W < 21) begin
            $error("unsupported parameters");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic idle_select_q;
    logic [7:0] watchdog_ctrl_reg_q;
    logic [PORT_W-1:0] porta_wake_enable_q;
    logic powered_down_flag_q;
    logic watchdog_timeout_flag_q;
    halt_idle_pkg::pmode_e mode_q;
    logic [WDT_W-1:0] wdt_cnt_q;
    logic [1:0] core_div_q;
    logic [7:0] int_armed_q;
    logic [10:0] sst_q;
    logic sst_low_pending_q;
    logic [PORT_W-1:0] pa_s1_q, pa_s2_q, pa_s3_q;
    logic [PORT_W-1:0] pa_stable_q;
    logic [2:0] rst_sync_q;
    logic rst_stable_q;

    wire wr = psel && penable && pwrite;
    wire halt_cmd = wr && paddr == `HI_ADDR_CMD && pwdata[`HI_CMD_HALT];
    wire clr_cmd = wr && paddr == `HI_ADDR_CMD && pwdata[`HI_CMD_CLRWDT];
    wire idle_core_clock_enable = watchdog_ctrl_reg_q[`HI_WATCHDOG_CTRL_REG_CORE_CLOCK_ON];
    wire [2:0] watchdog_divider_select = watchdog_ctrl_reg_q[`HI_WATCHDOG_CTRL_REG_WS_HI:`HI_WATCHDOG_CTRL_REG_WS_LO];
    wire [3:0] watchdog_soft_enable = watchdog_ctrl_reg_q[`HI_WATCHDOG_CTRL_REG_EN_HI:`HI_WATCHDOG_CTRL_REG_EN_LO];
    wire wdt_on = cfg_wdt_enable || watchdog_soft_enable != `HI_WDT_OFF_CODE; // RULE22
    wire lp = mode_q != halt_idle_pkg::RUN && mode_q != halt_idle_pkg::OSC_WAIT;

    ////////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states
    assign pready = 1'b1;
    wire known = paddr == `HI_ADDR_SYSTEM_MODE_REG || paddr == `HI_ADDR_WATCHDOG_CTRL_REG || paddr == `HI_ADDR_STAT
        || paddr == `HI_ADDR_CMD || paddr == `HI_ADDR_PORTA_WAKE_ENABLE || paddr == `HI_ADDR_INTF;
    assign pslverr = psel && penable && !known;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `HI_ADDR_SYSTEM_MODE_REG: prdata <= {31'h0, idle_select_q};
                `HI_ADDR_WATCHDOG_CTRL_REG: prdata <= {24'h0, watchdog_ctrl_reg_q};
                `HI_ADDR_STAT: prdata <= {27'h0, fast_osc_ready, osc_startup_busy,
                    (mode_q != halt_idle_pkg::RUN), watchdog_timeout_flag_q,
                    powered_down_flag_q};
                `HI_ADDR_PORTA_WAKE_ENABLE: prdata <= {{(32-PORT_W){1'b0}}, porta_wake_enable_q};
                `HI_ADDR_INTF: prdata <= {24'h0, int_armed_q};
                default: prdata <= 32'h0;
            endcase
        end
    end

    // Registers hold value through any low-power mode
    always_ff @(posedge pclk or negedge presetn) begin // RULE6
        if (!presetn) begin
            idle_select_q <= 1'b0;
            watchdog_ctrl_reg_q <= `HI_WATCHDOG_CTRL_REG_RST;
            porta_wake_enable_q <= '0;
        end else if (wr) begin
            if (paddr == `HI_ADDR_SYSTEM_MODE_REG) idle_select_q <= pwdata[`HI_SYSTEM_MODE_REG_IDLE_SEL];
            if (paddr == `HI_ADDR_WATCHDOG_CTRL_REG) watchdog_ctrl_reg_q <= pwdata[7:0];
            if (paddr == `HI_ADDR_PORTA_WAKE_ENABLE) porta_wake_enable_q <= pwdata[PORT_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    always_ff @(posedge pclk or negedge presetn) begin // RULE24
        if (!presetn) begin
            pa_s1_q <= '1;
            pa_s2_q <= '1;
            pa_s3_q <= '1;
            pa_stable_q <= '1;
            rst_sync_q <= 3'h7;
            rst_stable_q <= 1'b1;
        end else begin
            pa_s1_q <= porta_pin;
            pa_s2_q <= pa_s1_q;
            pa_s3_q <= pa_s2_q;
            rst_sync_q <= {rst_sync_q[1:0], ext_reset_n};
            for (int i = 0; i < PORT_W; i++) begin
                if (pa_s2_q[i] == pa_s3_q[i]) pa_stable_q[i] <= pa_s3_q[i];
            end
            if (rst_sync_q[1] == rst_sync_q[2]) rst_stable_q <= rst_sync_q[2];
        end
    end

    wire [PORT_W-1:0] pa_fall = pa_stable_q & ~pa_s3_q & ~pa_s2_q;
    wire pa_wake = |(pa_fall & porta_wake_enable_q); // RULE11
    wire ext_rst = !rst_stable_q;
    wire int_wake = |(int_request & int_armed_q); // RULE14

    // Only interrupts clear at halt may wake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_armed_q <= 8'h0;
        end else if (halt_cmd && mode_q == halt_idle_pkg::RUN) begin
            int_armed_q <= ~int_request; // RULE14
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog base clock and counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_div_q <= 2'h0;
        end else if (core_clock_en) begin
            core_div_q <= core_div_q + 2'h1;
        end
    end

    wire core_tick = core_clock_en && core_div_q == `HI_CORE_DIV; // RULE17
    wire wdt_src_tick = cfg_wdt_src_core ? core_tick : sub_clock_tick; // RULE17 RULE19
    wire wdt_tick = wdt_on && watchdog_base_en && wdt_src_tick; // RULE3 RULE4 RULE20
    wire [4:0] ws_bit = 5'(`HI_WS_BASE) + 5'(watchdog_divider_select);
    wire wdt_ovf = wdt_tick && wdt_cnt_q[ws_bit]; // RULE18

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_cnt_q <= '0;
        end else if (halt_cmd || clr_cmd || wdt_ovf || ext_rst) begin
            wdt_cnt_q <= '0; // RULE3 RULE4 RULE21
        end else if (wdt_tick) begin
            wdt_cnt_q <= wdt_cnt_q + WDT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= halt_idle_pkg::RUN;
        end else if (ext_rst) begin
            mode_q <= halt_idle_pkg::RUN; // RULE8
        end else begin
            unique case (mode_q)
                halt_idle_pkg::RUN: begin
                    if (halt_cmd) begin // RULE23
                        if (idle_select_q && !idle_core_clock_enable)
                            mode_q <= halt_idle_pkg::IDLE_CORE_OFF; // RULE1
                        else if (idle_select_q)
                            mode_q <= halt_idle_pkg::IDLE_CORE_ON; // RULE2
                        else if (!wdt_on && !lvd_on)
                            mode_q <= halt_idle_pkg::DEEP_SLEEP; // RULE21
                        else
                            mode_q <= halt_idle_pkg::LIGHT_SLEEP;
                    end
                end
                halt_idle_pkg::DEEP_SLEEP: begin
                    if (pa_wake || int_wake || wdt_ovf) mode_q <= halt_idle_pkg::OSC_WAIT;
                end
                halt_idle_pkg::OSC_WAIT: begin
                    if (fast_osc_ready && sst_q == 11'h0) mode_q <= halt_idle_pkg::RUN; // RULE16
                end
                halt_idle_pkg::IDLE_CORE_OFF, halt_idle_pkg::IDLE_CORE_ON,
                halt_idle_pkg::LIGHT_SLEEP: begin
                    if (pa_wake || int_wake || wdt_ovf) mode_q <= halt_idle_pkg::RUN; // RULE7
                end
                default: mode_q <= halt_idle_pkg::RUN;
            endcase
        end
    end

    // Shared startup counter, high crystal first
    always_ff @(posedge pclk or negedge presetn) begin // RULE15
        if (!presetn) begin
            sst_q <= 11'h0;
            sst_low_pending_q <= 1'b0;
        end else if (mode_q == halt_idle_pkg::DEEP_SLEEP && (pa_wake || int_wake || wdt_ovf)) begin
            sst_q <= `HI_OSC_SST;
            sst_low_pending_q <= 1'b1;
        end else if (sst_q != 11'h0) begin
            sst_q <= sst_q - 11'h1;
        end else if (sst_low_pending_q && mode_q == halt_idle_pkg::RUN) begin
            sst_q <= `HI_OSC_SST;
            sst_low_pending_q <= 1'b0;
        end
    end

    // Status flags, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            powered_down_flag_q <= 1'b0;
            watchdog_timeout_flag_q <= 1'b0;
        end else begin
            if (halt_cmd && mode_q == halt_idle_pkg::RUN)
                powered_down_flag_q <= 1'b1; // RULE5 RULE9
            else if (clr_cmd || ext_rst)
                powered_down_flag_q <= 1'b0; // RULE9
            if (wdt_ovf)
                watchdog_timeout_flag_q <= 1'b1; // RULE10
            else if (halt_cmd || ext_rst)
                watchdog_timeout_flag_q <= 1'b0; // RULE5
        end
    end

    // Wake result pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full_reset <= 1'b0;
            watchdog_reset <= 1'b0;
            int_service <= 1'b0;
            resume_after_halt <= 1'b0;
        end else begin
            full_reset <= ext_rst; // RULE8
            watchdog_reset <= wdt_ovf; // RULE8 RULE10
            int_service <= lp && !wdt_ovf && !pa_wake && |(int_request & int_armed_q & int_enable)
                && !stack_full; // RULE13
            resume_after_halt <= lp && !wdt_ovf && (pa_wake || (int_wake
                && (!(|(int_request & int_armed_q & int_enable)) || stack_full))); // RULE11 RULE12
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        core_clock_en = mode_q == halt_idle_pkg::RUN || mode_q == halt_idle_pkg::IDLE_CORE_ON;
        time_base_clock_en = mode_q == halt_idle_pkg::RUN || mode_q == halt_idle_pkg::IDLE_CORE_ON
            || mode_q == halt_idle_pkg::IDLE_CORE_OFF; // RULE1 RULE2
        sub_clock_en = wdt_on && mode_q != halt_idle_pkg::DEEP_SLEEP; // RULE20
        watchdog_base_en = sub_clock_en && (core_clock_en || !cfg_wdt_src_core); // RULE3
        osc_startup_busy = sst_q != 11'h0;
        halted = mode_q != halt_idle_pkg::RUN;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode entry checks
    halt_sets_pdf_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
        halt_cmd && mode_q == halt_idle_pkg::RUN && !wdt_ovf |=> powered_down_flag_q
        && !watchdog_timeout_flag_q) else $error("halt flags wrong");

    idle_off_mode_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
        halt_cmd && mode_q == halt_idle_pkg::RUN && idle_select_q && !idle_core_clock_enable
        && !ext_rst |=> !core_clock_en && time_base_clock_en) else $error("idle_core_off_mode clocks");

    idle_on_mode_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
        halt_cmd && mode_q == halt_idle_pkg::RUN && idle_select_q && idle_core_clock_enable
        && !ext_rst |=> core_clock_en && halted) else $error("idle_core_on_mode clocks");

    run_clocks_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
        mode_q == halt_idle_pkg::RUN |-> core_clock_en && time_base_clock_en && !halted)
        else $error("run clocks");

    deep_sleep_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE21
        halt_cmd && mode_q == halt_idle_pkg::RUN && !idle_select_q && !wdt_on && !lvd_on
        && !ext_rst |=> mode_q == halt_idle_pkg::DEEP_SLEEP) else $error("deep sleep");

    deep_clocks_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE21
        mode_q == halt_idle_pkg::DEEP_SLEEP |-> !core_clock_en && !time_base_clock_en
        && !watchdog_base_en) else $error("deep clocks");

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog checks
    halt_clears_wdt_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
        halt_cmd |=> wdt_cnt_q == '0) else $error("wdt not cleared");

    core_src_stop_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
        mode_q == halt_idle_pkg::IDLE_CORE_OFF && cfg_wdt_src_core |-> !watchdog_base_en)
        else $error("core source runs");

    core_stop_cnt_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
        mode_q == halt_idle_pkg::IDLE_CORE_OFF && cfg_wdt_src_core && !halt_cmd && !clr_cmd
        && !ext_rst |=> $stable(wdt_cnt_q)) else $error("wdt counted");

    idle_on_count_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
        mode_q == halt_idle_pkg::IDLE_CORE_ON && wdt_on |-> watchdog_base_en)
        else $error("idle_core_on_mode wdt stopped");

    soft_off_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE22
        !cfg_wdt_enable && watchdog_soft_enable == `HI_WDT_OFF_CODE |-> !sub_clock_en)
        else $error("wdt not off");

    wdt_wake_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
        wdt_ovf |=> watchdog_timeout_flag_q && watchdog_reset) else $error("timeout");

    timeout_kept_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
        !wdt_ovf && !halt_cmd && !ext_rst |=> $stable(watchdog_timeout_flag_q))
        else $error("timeout flag moved");

    clr_pdf_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
        clr_cmd && !(halt_cmd && mode_q == halt_idle_pkg::RUN) |=> !powered_down_flag_q)
        else $error("pdf not cleared");

    ////////////////////////////////////////////////////////////////////////////
    // Wake checks
    ext_wake_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
        ext_rst |=> full_reset && mode_q == halt_idle_pkg::RUN) else $error("no full reset");

    pa_wake_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
        lp && mode_q != halt_idle_pkg::DEEP_SLEEP && pa_wake |=> !halted)
        else $error("no port wake");

    pending_no_wake_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
        mode_q == halt_idle_pkg::IDLE_CORE_ON && !pa_wake && !wdt_ovf && !ext_rst && !int_wake
        |=> mode_q == halt_idle_pkg::IDLE_CORE_ON) else $error("woke without cause");

    int_service_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
        lp && !wdt_ovf && !pa_wake && !stack_full && |(int_request & int_armed_q & int_enable)
        |=> int_service) else $error("no int service");

    resume_full_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
        lp && !wdt_ovf && int_wake && stack_full |=> resume_after_halt && !int_service)
        else $error("serviced on full stack");

    regs_kept_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
        halted && !wr |=> $stable(watchdog_ctrl_reg_q) && $stable(idle_select_q)
        && $stable(porta_wake_enable_q)) else $error("register lost");

    osc_wait_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
        mode_q == halt_idle_pkg::OSC_WAIT && !fast_osc_ready && !ext_rst
        |=> mode_q == halt_idle_pkg::OSC_WAIT) else $error("ran before ready");

    sst_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
        mode_q == halt_idle_pkg::OSC_WAIT && sst_q != 11'h0 && !ext_rst
        |=> mode_q == halt_idle_pkg::OSC_WAIT) else $error("ran before startup");

endmodule

// file: rtl/halt_idle_consts.svh
`ifndef HALT_IDLE_CONSTS_SVH
`define HALT_IDLE_CONSTS_SVH
// Register byte addresses
`define HI_ADDR_SYSTEM_MODE_REG 12'h000
`define HI_ADDR_WATCHDOG_CTRL_REG 12'h004
`define HI_ADDR_STAT 12'h008
`define HI_ADDR_CMD 12'h00c
`define HI_ADDR_PORTA_WAKE_ENABLE 12'h010
`define HI_ADDR_INTF 12'h014
// Field positions
`define HI_SYSTEM_MODE_REG_IDLE_SEL 0
`define HI_WATCHDOG_CTRL_REG_CORE_CLOCK_ON 7
`define HI_WATCHDOG_CTRL_REG_WS_LO 4
`define HI_WATCHDOG_CTRL_REG_WS_HI 6
`define HI_WATCHDOG_CTRL_REG_EN_LO 0
`define HI_WATCHDOG_CTRL_REG_EN_HI 3
`define HI_CMD_HALT 0
`define HI_CMD_CLRWDT 1
// Reset values and codes
`define HI_WATCHDOG_CTRL_REG_RST 8'h7a
`define HI_WDT_OFF_CODE 4'ha
`define HI_WS_BASE 13
`define HI_CORE_DIV 2'h3
`define HI_OSC_SST 11'h3ff
`endif

// file: rtl/halt_idle_pkg.sv
package halt_idle_pkg;
    typedef enum logic [2:0] {
        RUN, IDLE_CORE_OFF, IDLE_CORE_ON, DEEP_SLEEP, LIGHT_SLEEP, OSC_WAIT
    } pmode_e;
endpackage

// file: bench/pin_model.sv
`timescale 1ns/1ns
module pin_model #(
    parameter int PORT_W = 8
) (
    // Clock
    input wire logic pclk,
    // Requests from the bench, one-cycle pulses
    input wire logic [PORT_W-1:0] fall_req,
    input wire logic reset_req,
    // Pins, pulled high while idle
    output logic ext_reset_n,
    output logic [PORT_W-1:0] porta_pin
);
    logic [3:0] low_cnt_q = 4'h0;
    logic [PORT_W-1:0] pins_q = '1;
    logic reset_pin_q = 1'b1;
    assign porta_pin = pins_q;
    assign ext_reset_n = reset_pin_q;
    // Pins held low 8 cycles so the synchroniser sees them
    always @(posedge pclk) begin
        if (|fall_req || reset_req) begin
            pins_q <= ~fall_req;
            reset_pin_q <= ~reset_req;
            low_cnt_q <= 4'h8;
        end else if (low_cnt_q != 4'h0) begin
            low_cnt_q <= low_cnt_q - 4'h1;
            if (low_cnt_q == 4'h1) begin
                pins_q <= '1;
                reset_pin_q <= 1'b1;
            end
        end
    end
endmodule

// file: bench/tb.sv
`timescale 1ns/1ns
`include "halt_idle_consts.svh"
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic pready, pslverr, serr;
    logic cfg_wdt_enable = 1'b0, cfg_wdt_src_core = 1'b0, lvd_on = 1'b0, sub_clock_tick = 1'b1;
    logic [7:0] int_request = 8'h00, int_enable = 8'h00, fall_req = 8'h00;
    logic stack_full = 1'b0, fast_osc_ready = 1'b1, reset_req = 1'b0, ext_reset_n;
    logic [7:0] porta_pin;
    logic core_clock_en, time_base_clock_en, sub_clock_en, watchdog_base_en, osc_startup_busy;
    logic halted, full_reset, watchdog_reset, int_service, resume_after_halt;
    logic [3:0] seen = 4'h0;
    logic seen_clr = 1'b0;
    int n_errors = 0;
    int checks = 0;

    always #5 pclk = ~pclk;

    halt_idle_wakeup_control i_halt_idle_wakeup_control (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg_wdt_enable(cfg_wdt_enable),
        .cfg_wdt_src_core(cfg_wdt_src_core), .lvd_on(lvd_on), .sub_clock_tick(sub_clock_tick),
        .ext_reset_n(ext_reset_n), .porta_pin(porta_pin), .int_request(int_request),
        .int_enable(int_enable), .stack_full(stack_full), .fast_osc_ready(fast_osc_ready),
        .core_clock_en(core_clock_en), .time_base_clock_en(time_base_clock_en),
        .sub_clock_en(sub_clock_en), .watchdog_base_en(watchdog_base_en),
        .osc_startup_busy(osc_startup_busy), .halted(halted), .full_reset(full_reset),
        .watchdog_reset(watchdog_reset), .int_service(int_service),
        .resume_after_halt(resume_after_halt));
    pin_model i_pin_model (.pclk(pclk), .fall_req(fall_req), .reset_req(reset_req),
        .ext_reset_n(ext_reset_n), .porta_pin(porta_pin));

    ////////////////////////////////////////////////////////////////////////////////
    // Sticky record of the wake result pulses
    always @(posedge pclk) begin
        if (seen_clr) begin
            seen <= 4'h0;
        end else begin
            seen <= seen | {full_reset, watchdog_reset, int_service, resume_after_halt};
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rdv = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] msk,
                          input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rdv & msk);
    endtask

    task automatic halt();
        seen_clr <= 1'b1;
        apb(1'b1, `HI_ADDR_CMD, 32'h1);
        seen_clr <= 1'b0;
        @(posedge pclk);
    endtask

    // Bounded wait for a recorded pulse
    task automatic wait_seen(input int idx, input int lim, input string nm);
        int k;
        k = 0;
        while (seen[idx] !== 1'b1 && k < lim) begin
            @(posedge pclk);
            k++;
        end
        chk(nm, 1, seen[idx]);
    endtask

    task automatic port_fall(input logic [7:0] m);
        @(posedge pclk);
        fall_req <= m;
        @(posedge pclk);
        fall_req <= 8'h00;
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #300000;
        n_errors++;
        results();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("watchdog_ctrl_reg reset", `HI_ADDR_WATCHDOG_CTRL_REG, 32'hff, 32'h7a);
        chk("sub clock off when disabled", 0, sub_clock_en);
        apb(1'b0, 12'h0f0, 32'h0);
        chk("unmapped error", 1, serr);
        $display("test reset done");
        // Idle with core clock off, port A wake
        apb(1'b1, `HI_ADDR_SYSTEM_MODE_REG, 32'h1);
        apb(1'b1, `HI_ADDR_PORTA_WAKE_ENABLE, 32'h2);
        halt();
        chk("idle_core_off_mode core", 0, core_clock_en);
        chk("idle_core_off_mode time base", 1, time_base_clock_en);
        chk("idle_core_off_mode halted", 1, halted);
        rd_chk("idle_core_off_mode status", `HI_ADDR_STAT, 32'h7, 32'h5);
        rd_chk("idle_core_off_mode system_mode_reg kept", `HI_ADDR_SYSTEM_MODE_REG, 32'h1, 32'h1);
        port_fall(8'h01);
        repeat (12) @(posedge pclk);
        chk("masked pin no wake", 1, halted);
        port_fall(8'h02);
        wait_seen(0, 20, "port resume");
        chk("port wake run", 0, halted);
        apb(1'b1, `HI_ADDR_CMD, 32'h2);
        rd_chk("clear wdt pd", `HI_ADDR_STAT, 32'h1, 32'h0);
        $display("test idle core off done");
        // Idle with core clock on, interrupt wake
        apb(1'b1, `HI_ADDR_WATCHDOG_CTRL_REG, 32'hfa);
        int_request <= 8'h04;
        int_enable <= 8'h05;
        halt();
        chk("idle_core_on_mode core", 1, core_clock_en);
        chk("idle_core_on_mode halted", 1, halted);
        repeat (10) @(posedge pclk);
        chk("pending no wake", 1, halted);
        int_request <= 8'h05;
        wait_seen(1, 10, "int service");
        int_request <= 8'h00;
        halt();
        int_request <= 8'h02;
        wait_seen(0, 10, "disabled int resume");
        chk("no service", 0, seen[1]);
        int_request <= 8'h00;
        stack_full <= 1'b1;
        halt();
        int_request <= 8'h01;
        wait_seen(0, 10, "stack full resume");
        chk("no service full", 0, seen[1]);
        int_request <= 8'h00;
        stack_full <= 1'b0;
        $display("test idle core on done");
        // Watchdog overflow in idle core off, sub clock source, 2^13 ticks
        cfg_wdt_src_core <= 1'b1;
        apb(1'b1, `HI_ADDR_WATCHDOG_CTRL_REG, 32'h05);
        halt();
        chk("core src wdt stop", 0, watchdog_base_en);
        port_fall(8'h02);
        wait_seen(0, 20, "core src wake");
        cfg_wdt_src_core <= 1'b0;
        halt();
        chk("wdt base on", 1, watchdog_base_en);
        repeat (8000) @(posedge pclk);
        chk("no early overflow", 0, seen[2]);
        wait_seen(2, 400, "wdt reset");
        chk("no full reset", 0, seen[3]);
        rd_chk("timeout flags", `HI_ADDR_STAT, 32'h3, 32'h3);
        apb(1'b1, `HI_ADDR_WATCHDOG_CTRL_REG, 32'h7a);
        $display("test watchdog done");
        // External reset wake
        halt();
        @(posedge pclk);
        reset_req <= 1'b1;
        @(posedge pclk);
        reset_req <= 1'b0;
        wait_seen(3, 20, "full reset");
        repeat (20) @(posedge pclk);
        $display("test external reset done");
        // Light sleep with detector on, port A wake
        apb(1'b1, `HI_ADDR_SYSTEM_MODE_REG, 32'h0);
        lvd_on <= 1'b1;
        halt();
        chk("light core", 0, core_clock_en);
        chk("light time base", 0, time_base_clock_en);
        chk("light halted", 1, halted);
        port_fall(8'h02);
        wait_seen(0, 20, "light sleep wake");
        lvd_on <= 1'b0;
        // Deep sleep and oscillator startup
        apb(1'b1, `HI_ADDR_SYSTEM_MODE_REG, 32'h0);
        apb(1'b1, `HI_ADDR_PORTA_WAKE_ENABLE, 32'h1);
        fast_osc_ready <= 1'b0;
        halt();
        chk("deep core", 0, core_clock_en);
        chk("deep time base", 0, time_base_clock_en);
        chk("deep wdt base", 0, watchdog_base_en);
        port_fall(8'h01);
        repeat (200) @(posedge pclk);
        chk("startup busy", 1, osc_startup_busy);
        repeat (1000) @(posedge pclk);
        chk("wait for osc ready", 1, halted);
        fast_osc_ready <= 1'b1;
        repeat (60) @(posedge pclk);
        chk("deep wake run", 0, halted);
        $display("test deep sleep done");
        results();
    end
endmodule
